/* File: hdl/uam_monitor.sv */
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// What this block does, and what the host must do
// R1 - each alarm type sets its own status bit, kept until host writes one
// R2 - serializer pll out of lock raises an alarm
// R3 - link enabled but transmitter not in data state raises an alarm
// R4 - reference pulse that realigns internal clocks raises an alarm
// R5 - summary alarm only from unmasked types; masked types still set status
// R6 - status pin set to alarm mode goes high while alarm indicated
// R7 - any cycle of oscillator accumulator mismatch sets sticky oscillator flag
// R8 - oscillator compare counts only after oscillators were synchronised
// R9 - host programs matching channel a and b frequency and phase words
// R10 - host follows the enable, program, sync, clear, monitor order
// R11 - host repeats sync, clear, monitor after word change or power-down
// R12 - any half-rate cycle of clock mismatch sets sticky clock flag
// R13 - host clears clock flag after leaving global power-down
// R14 - any lane buffer under or overflow sets buffer flag and lane flag
// R15 - per-lane flag goes to one for a lane with disturbed pointers
// R16 - auto reinit option resets serializers, buffers and link on buffer alarm
// R17 - link disabled holds link in reset, serializers down, clocks gated
// R18 - an event in the clearing cycle leaves the flag set
module uam_monitor
	import uam_pkg::*;
#(
	parameter int LANES  = 8,
	parameter int ACC_W  = 32,
	parameter int CLKS_W = 4
) (
	// clock, reset, enable
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              ce,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic      [31:0]       prdata,
	// alarm sources
	input  wire logic              pll_locked,
	input  wire logic              link_in_data_state,
	input  wire logic              realign_pulse,
	input  wire logic              ref_pulse_sync,
	input  wire logic              lane_align_start,
	input  wire logic [ACC_W-1:0]  osc_acc_a,
	input  wire logic [ACC_W-1:0]  osc_acc_b,
	input  wire logic              half_clk_en,
	input  wire logic [CLKS_W-1:0] clks_a,
	input  wire logic [CLKS_W-1:0] clks_b,
	input  wire logic [LANES-1:0]  lane_buffer_err,
	input  wire logic              cal_status_in,
	// alarm indication
	output logic                   summary_alarm,
	output logic                   status_output_pin,
	output logic                   irq,
	// link section control
	output logic                   link_block_reset,
	output logic                   lane_buffer_reset,
	output logic                   serializer_reset,
	output logic                   serializer_powerdown,
	output logic                   link_clock_enable
);

	logic [NUM_ALARMS-1:0] alarm_status_bits;
	logic [LANES-1:0]      per_lane_buffer_flags;
	logic [NUM_ALARMS-1:0] alarm_mask;
	logic [NUM_ALARMS-1:0] irq_mask;
	logic [NUM_ALARMS-1:0] irq_stat;
	logic [CTRL_W-1:0]     ctrl;
	logic                  osc_valid;
	logic [LANES-1:0]      lane_err_q;
	uam_ri_e               ri_state;
	logic [RI_CNT_W-1:0]   ri_cnt;
	logic                  rd_ready;

	logic [NUM_ALARMS-1:0] next_alarm_mask;
	logic [NUM_ALARMS-1:0] next_irq_mask;
	logic [NUM_ALARMS-1:0] next_irq_stat;
	logic [CTRL_W-1:0]     next_ctrl;
	logic [31:0]           next_prdata;
	logic                  next_summary;
	logic                  next_pin;
	logic                  next_irq;
	logic                  next_osc_valid;
	uam_ri_e               next_ri_state;
	logic [RI_CNT_W-1:0]   next_ri_cnt;
	logic                  next_link_rst;
	logic                  next_ser_rst;
	logic                  next_ser_pd;
	logic                  next_clk_en;
	logic                  next_rd_ready;

	logic [NUM_ALARMS-1:0] alarm_event;
	logic [NUM_ALARMS-1:0] status_clr;
	logic [LANES-1:0]      lane_clr;
	logic                  link_enable;
	logic                  wr_acc;
	logic                  rd_acc;
	logic                  sync_event;
	logic                  buffer_err_rise;
	uam_reg_e              setup_sel;
	uam_reg_e              acc_sel;

	assign link_enable = ctrl[CTL_LINK_EN];

	// apb handshake: a read waits until its data is captured, ce low stalls the bus
	assign acc_sel   = uam_decode(paddr);
	assign setup_sel = uam_decode(paddr);
	assign pready    = ce & (pwrite | rd_ready);
	assign pslverr   = psel & penable & (acc_sel == REG_NONE);
	assign wr_acc    = pready & psel & penable & pwrite;
	assign rd_acc    = pready & psel & penable & ~pwrite;

	// alarm events, sampled every cycle as levels
	always_comb begin
		alarm_event              = '0;
		alarm_event[ALM_FIFO]    = |lane_buffer_err;                          // [R14]
		alarm_event[ALM_PLL]     = ~pll_locked;                               // [R2]
		alarm_event[ALM_LINK]    = link_enable & ~link_in_data_state;         // [R3]
		alarm_event[ALM_REALIGN] = realign_pulse;                             // [R4]
		alarm_event[ALM_OSC]     = osc_valid & (osc_acc_a != osc_acc_b);      // [R7] [R8]
		alarm_event[ALM_CLK]     = half_clk_en & (clks_a != clks_b);          // [R12]
	end

	// write-one-to-clear strobes for the sticky flags
	always_comb begin
		status_clr = '0;
		lane_clr   = '0;
		if (wr_acc && acc_sel == REG_STATUS) begin
			status_clr = pwdata[NUM_ALARMS-1:0];                              // [R1]
		end
		if (wr_acc && acc_sel == REG_LANES) begin
			lane_clr = pwdata[LANES-1:0];
		end
	end

	uam_sticky #(
		.W (NUM_ALARMS)
	) u_status (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.set   (alarm_event),
		.clr   (status_clr),
		.q     (alarm_status_bits)
	);                                                                        // [R1] [R18]

	uam_sticky #(
		.W (LANES)
	) u_lanes (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.set   (lane_buffer_err),
		.clr   (lane_clr),
		.q     (per_lane_buffer_flags)
	);                                                                        // [R15]

	// register file and indication outputs
	always_comb begin
		next_ctrl      = ctrl;
		next_alarm_mask = alarm_mask;
		next_irq_mask  = irq_mask;
		next_prdata    = prdata;
		if (wr_acc) begin
			unique case (acc_sel)
				REG_CTRL:     next_ctrl       = pwdata[CTRL_W-1:0];
				REG_MASK:     next_alarm_mask = pwdata[NUM_ALARMS-1:0];
				REG_IRQ_MASK: next_irq_mask   = pwdata[NUM_ALARMS-1:0];
				default:      next_ctrl       = ctrl;
			endcase
		end
		// read data leaves a flop: captured in setup, or in access if ce stalled setup
		if (psel && !pwrite && !rd_ready) begin
			next_prdata = '0;
			unique case (setup_sel)
				REG_STATUS:   next_prdata[NUM_ALARMS-1:0] = alarm_status_bits;
				REG_MASK:     next_prdata[NUM_ALARMS-1:0] = alarm_mask;
				REG_SUMMARY:  next_prdata[0]              = summary_alarm;
				REG_LANES:    next_prdata[LANES-1:0]      = per_lane_buffer_flags;
				REG_CTRL:     next_prdata[CTRL_W-1:0]     = ctrl;
				REG_IRQ_STAT: next_prdata[NUM_ALARMS-1:0] = irq_stat;
				REG_IRQ_MASK: next_prdata[NUM_ALARMS-1:0] = irq_mask;
				REG_NONE:     next_prdata                 = '0;
			endcase
		end
		// read clears only the bits it returned, so a later event is not lost
		next_irq_stat = irq_stat;
		if (rd_acc && acc_sel == REG_IRQ_STAT) begin
			next_irq_stat = irq_stat & ~prdata[NUM_ALARMS-1:0];
		end
		next_rd_ready = rd_ready ? ~rd_acc : (psel & ~pwrite);
		next_irq_stat = next_irq_stat | alarm_event;
		next_irq      = |(irq_stat & irq_mask);
		next_summary  = |(alarm_status_bits & ~alarm_mask);                  // [R5]
		next_pin      = ctrl[CTL_PIN_ALARM] ? summary_alarm : cal_status_in;  // [R6]
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl              <= CTRL_RST;
			alarm_mask        <= MASK_RST;
			irq_mask          <= IRQ_MASK_RST;
			irq_stat          <= '0;
			prdata            <= '0;
			summary_alarm     <= 1'b0;
			status_output_pin <= 1'b0;
			irq               <= 1'b0;
			rd_ready          <= 1'b0;
		end else if (ce) begin
			ctrl              <= next_ctrl;
			alarm_mask        <= next_alarm_mask;
			irq_mask          <= next_irq_mask;
			irq_stat          <= next_irq_stat;
			prdata            <= next_prdata;
			summary_alarm     <= next_summary;
			status_output_pin <= next_pin;
			irq               <= next_irq;
			rd_ready          <= next_rd_ready;
		end
	end

	// oscillator sync tracking and link section control
	assign sync_event      = ctrl[CTL_SYNC_SRC] ? lane_align_start : ref_pulse_sync;
	assign buffer_err_rise = |(lane_buffer_err & ~lane_err_q);

	always_comb begin
		next_osc_valid = osc_valid;
		// a disabled link restarts the oscillators, so they need a new sync
		if (!link_enable) begin
			next_osc_valid = 1'b0;                                            // [R8]
		end else if (sync_event) begin
			next_osc_valid = 1'b1;                                            // [R8]
		end
		next_ri_state = ri_state;
		next_ri_cnt   = ri_cnt;
		unique case (ri_state)
			RI_IDLE: begin
				if (link_enable && ctrl[CTL_AUTO_REINIT] && buffer_err_rise) begin
					next_ri_state = RI_HOLD;                                  // [R16]
					next_ri_cnt   = RI_CNT_W'(REINIT_CYCLES - 1);
				end
			end
			RI_HOLD: begin
				if (ri_cnt == '0) begin
					next_ri_state = RI_IDLE;
				end else begin
					next_ri_cnt = ri_cnt - 1'b1;
				end
			end
		endcase
		next_link_rst = ~link_enable | (next_ri_state == RI_HOLD);        // [R17] [R16]
		next_ser_rst  = next_ri_state == RI_HOLD;                           // [R16]
		next_ser_pd   = ~link_enable;                                       // [R17]
		next_clk_en   = link_enable;                                        // [R17]
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_valid            <= 1'b0;
			lane_err_q           <= '0;
			ri_state             <= RI_IDLE;
			ri_cnt               <= '0;
			link_block_reset     <= 1'b1;
			lane_buffer_reset    <= 1'b1;
			serializer_reset     <= 1'b0;
			serializer_powerdown <= 1'b1;
			link_clock_enable    <= 1'b0;
		end else if (ce) begin
			osc_valid            <= next_osc_valid;
			lane_err_q           <= lane_buffer_err;
			ri_state             <= next_ri_state;
			ri_cnt               <= next_ri_cnt;
			link_block_reset     <= next_link_rst;
			lane_buffer_reset    <= next_link_rst;
			serializer_reset     <= next_ser_rst;
			serializer_powerdown <= next_ser_pd;
			link_clock_enable    <= next_clk_en;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_status_held_set: assert property (                                     // [R1]
		ce && alarm_status_bits[ALM_PLL] && !status_clr[ALM_PLL]
		|=> alarm_status_bits[ALM_PLL]
	) else $error("alarm status bit dropped without a clear");

	a_pll_unlock_alarm: assert property (                                    // [R2]
		ce && !pll_locked |=> alarm_status_bits[ALM_PLL]
	) else $error("pll unlock did not set its alarm");

	a_link_idle_alarm: assert property (                                     // [R3]
		ce && ctrl[CTL_LINK_EN] && !link_in_data_state |=> alarm_status_bits[ALM_LINK]
	) else $error("idle enabled link did not set its alarm");

	a_realign_alarm: assert property (                                       // [R4]
		ce && realign_pulse |=> alarm_status_bits[ALM_REALIGN]
	) else $error("realign pulse did not set its alarm");

	a_summary_masked: assert property (                                      // [R5]
		ce ##1 1'b1 |-> summary_alarm == $past(|(alarm_status_bits & ~alarm_mask))
	) else $error("summary alarm disagrees with unmasked status");

	a_pin_alarm_mode: assert property (                                      // [R6]
		ce && ctrl[CTL_PIN_ALARM] |=> status_output_pin == $past(summary_alarm)
	) else $error("status pin does not follow the alarm");

	a_osc_upset_sets: assert property (                                      // [R7]
		ce && osc_valid && osc_acc_a != osc_acc_b |=> alarm_status_bits[ALM_OSC]
	) else $error("oscillator mismatch did not set its flag");

	a_osc_needs_sync: assert property (                                      // [R8]
		ce && !ctrl[CTL_LINK_EN] |=> !osc_valid ##0 !alarm_event[ALM_OSC]
	) else $error("oscillator compare active without sync");

	a_clk_upset_sets: assert property (                                      // [R12]
		ce && half_clk_en && clks_a != clks_b |=> alarm_status_bits[ALM_CLK]
	) else $error("clock mismatch did not set its flag");

	a_lane_flag_sets: assert property (                                      // [R14] [R15]
		ce && lane_buffer_err != '0
		|=> alarm_status_bits[ALM_FIFO]
		&& (per_lane_buffer_flags & $past(lane_buffer_err)) == $past(lane_buffer_err)
	) else $error("lane buffer error not flagged");

	a_reinit_pulse: assert property (                                        // [R16]
		ce && ri_state == RI_IDLE && ctrl[CTL_LINK_EN] && ctrl[CTL_AUTO_REINIT]
		&& buffer_err_rise |=> serializer_reset && link_block_reset && lane_buffer_reset
	) else $error("buffer alarm did not start reinitialisation");

	a_link_off_held: assert property (                                       // [R17]
		ce && !ctrl[CTL_LINK_EN]
		|=> link_block_reset && serializer_powerdown && !link_clock_enable
	) else $error("disabled link not held down");

	a_set_beats_clear: assert property (                                     // [R18]
		ce && !pll_locked && status_clr[ALM_PLL] |=> alarm_status_bits[ALM_PLL]
	) else $error("event lost against a clear");

	c_osc_upset: cover property (osc_valid && alarm_event[ALM_OSC]);
	c_reinit_done: cover property (ri_state == RI_HOLD ##1 ri_state == RI_IDLE);
	c_irq_raised: cover property (!irq ##1 irq);
	c_clear_alarm: cover property (alarm_status_bits[ALM_CLK] ##1 !alarm_status_bits[ALM_CLK]);

endmodule
`default_nettype wire

/* File: hdl/uam_pkg.sv */
package uam_pkg;

	// register byte offsets on the apb slave
	localparam logic [7:0] OFS_STATUS   = 8'h00;
	localparam logic [7:0] OFS_MASK     = 8'h04;
	localparam logic [7:0] OFS_SUMMARY  = 8'h08;
	localparam logic [7:0] OFS_LANES    = 8'h0c;
	localparam logic [7:0] OFS_CTRL     = 8'h10;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
	localparam int         ADDR_W       = 8;

	// alarm bit positions, shared by status, mask and irq registers
	localparam int NUM_ALARMS  = 6;
	localparam int ALM_FIFO    = 0;
	localparam int ALM_PLL     = 1;
	localparam int ALM_LINK    = 2;
	localparam int ALM_REALIGN = 3;
	localparam int ALM_OSC     = 4;
	localparam int ALM_CLK     = 5;

	// control register fields
	localparam int CTRL_W          = 4;
	localparam int CTL_LINK_EN     = 0;
	localparam int CTL_PIN_ALARM   = 1;
	localparam int CTL_AUTO_REINIT = 2;
	localparam int CTL_SYNC_SRC    = 3;

	// reset values
	localparam logic [NUM_ALARMS-1:0] MASK_RST     = 6'h00;
	localparam logic [NUM_ALARMS-1:0] IRQ_MASK_RST = 6'h00;
	localparam logic [CTRL_W-1:0]     CTRL_RST     = 4'h0;

	// reinitialise pulse length, least time rounded up
	localparam int CLK_NS        = 10;
	localparam int REINIT_NS     = 100;
	localparam int REINIT_CYCLES = (REINIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int RI_CNT_W      = $clog2(REINIT_CYCLES + 1);

	typedef enum {
		REG_NONE,
		REG_STATUS,
		REG_MASK,
		REG_SUMMARY,
		REG_LANES,
		REG_CTRL,
		REG_IRQ_STAT,
		REG_IRQ_MASK
	} uam_reg_e;

	typedef enum {
		RI_IDLE,
		RI_HOLD
	} uam_ri_e;

	function automatic uam_reg_e uam_decode(input logic [ADDR_W-1:0] addr);
		uam_reg_e r;
		r = REG_NONE;
		case (addr)
			OFS_STATUS:   r = REG_STATUS;
			OFS_MASK:     r = REG_MASK;
			OFS_SUMMARY:  r = REG_SUMMARY;
			OFS_LANES:    r = REG_LANES;
			OFS_CTRL:     r = REG_CTRL;
			OFS_IRQ_STAT: r = REG_IRQ_STAT;
			OFS_IRQ_MASK: r = REG_IRQ_MASK;
			default:      r = REG_NONE;
		endcase
		return r;
	endfunction

endpackage

/* File: hdl/uam_sticky.sv */
`timescale 1ns/1ps
`default_nettype none
module uam_sticky #(
	parameter int W = 1
) (
	// clock, reset, enable
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	// per-bit set and clear
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	// flags
	output var  logic [W-1:0] q
);

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic next_bit;
			// set beats a clear in the same cycle so no event is lost
			always_comb begin
				next_bit = set[i] | (q[i] & ~clr[i]);
			end
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					q[i] <= 1'b0;
				end else if (ce) begin
					q[i] <= next_bit;
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import uam_pkg::*;
;
	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              ce = 1'b1;
	logic              psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, osc_acc_a, osc_acc_b;
	logic              pll_locked, link_in_data_state, realign_pulse;
	logic              ref_pulse_sync, lane_align_start, half_clk_en, cal_status_in;
	logic [3:0]        clks_a, clks_b;
	logic [7:0]        lane_buffer_err;
	logic              summary_alarm, status_output_pin, irq, link_block_reset;
	logic              lane_buffer_reset, serializer_reset, serializer_powerdown;
	logic              link_clock_enable;
	int                num_errors = 0;
	int                checks = 0;

	uam_monitor u_uam_monitor (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .pslverr(pslverr), .prdata(prdata), .pll_locked(pll_locked),
		.link_in_data_state(link_in_data_state), .realign_pulse(realign_pulse),
		.ref_pulse_sync(ref_pulse_sync), .lane_align_start(lane_align_start),
		.osc_acc_a(osc_acc_a), .osc_acc_b(osc_acc_b), .half_clk_en(half_clk_en),
		.clks_a(clks_a), .clks_b(clks_b), .lane_buffer_err(lane_buffer_err),
		.cal_status_in(cal_status_in), .summary_alarm(summary_alarm),
		.status_output_pin(status_output_pin), .irq(irq),
		.link_block_reset(link_block_reset), .lane_buffer_reset(lane_buffer_reset),
		.serializer_reset(serializer_reset), .serializer_powerdown(serializer_powerdown),
		.link_clock_enable(link_clock_enable));

	always #5 clk = ~clk;

	task automatic report_and_stop();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string m);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t %s got %b exp %b", $time, m, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// ev drops pll lock for exactly the access cycle, so the event meets the write edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			input logic ev, output logic [31:0] q, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		if (ev)
			pll_locked <= 1'b0;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (ev)
			pll_locked <= 1'b1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, 1'b0, q, e);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, 1'b0, q, e);
		chk_word(q, exp, m);
	endtask

	task automatic pll_drop();
		@(posedge clk) pll_locked <= 1'b0;
		@(posedge clk) pll_locked <= 1'b1;
		cyc(4);
	endtask

	task automatic osc_glitch();
		@(posedge clk) osc_acc_b <= 32'h1234_5679;
		@(posedge clk) osc_acc_b <= 32'h1234_5678;
		cyc(1);
	endtask

	task automatic sync_pulse(input logic lane);
		@(posedge clk);
		if (lane)
			lane_align_start <= 1'b1;
		else
			ref_pulse_sync <= 1'b1;
		@(posedge clk);
		lane_align_start <= 1'b0;
		ref_pulse_sync <= 1'b0;
	endtask

	task automatic t_reset();
		@(negedge clk);
		chk_bit(link_block_reset, 1'b1, "link reset");
		chk_bit(serializer_powerdown, 1'b1, "ser pd");
		chk_bit(link_clock_enable, 1'b0, "link clk");
		chk_bit(serializer_reset, 1'b0, "ser reset");
		rdc(OFS_STATUS, 32'h0, "status rst");
		rdc(OFS_MASK, 32'h0, "mask rst");
		rdc(OFS_CTRL, 32'h0, "ctrl rst");
		rdc(OFS_IRQ_MASK, 32'h0, "irq mask rst");
		$display("test reset done");
	endtask

	task automatic t_ce();
		ce <= 1'b0;
		pll_locked <= 1'b0;
		cyc(3);
		ce <= 1'b1;
		pll_locked <= 1'b1;
		rdc(OFS_STATUS, 32'h0, "ce freezes state");
		$display("test ce done");
	endtask

	task automatic t_pll();
		logic [31:0] q;
		logic        e;
		pll_drop();
		chk_bit(summary_alarm, 1'b1, "summary on");
		rdc(OFS_STATUS, 32'h2, "pll bit");
		rdc(OFS_SUMMARY, 32'h1, "summary reg");
		wr(OFS_STATUS, 32'h1);
		rdc(OFS_STATUS, 32'h2, "other bit cleared");
		apb(1'b1, OFS_STATUS, 32'h2, 1'b1, q, e);
		rdc(OFS_STATUS, 32'h2, "event wins clear");
		wr(OFS_STATUS, 32'h2);
		rdc(OFS_STATUS, 32'h0, "w1c");
		cyc(3);
		chk_bit(summary_alarm, 1'b0, "summary off");
		$display("test pll done");
	endtask

	task automatic t_mask();
		wr(OFS_MASK, 32'hffff_ffff);
		rdc(OFS_MASK, 32'h3f, "mask width");
		pll_drop();
		chk_bit(summary_alarm, 1'b0, "masked summary");
		rdc(OFS_STATUS, 32'h2, "masked still sets");
		wr(OFS_STATUS, 32'h2);
		wr(OFS_MASK, 32'h0);
		@(posedge clk) realign_pulse <= 1'b1;
		@(posedge clk) realign_pulse <= 1'b0;
		rdc(OFS_STATUS, 32'h8, "realign");
		wr(OFS_STATUS, 32'h8);
		$display("test mask done");
	endtask

	task automatic t_link();
		wr(OFS_CTRL, 32'h1);
		cyc(2);
		chk_bit(link_block_reset, 1'b0, "link run");
		chk_bit(serializer_powerdown, 1'b0, "ser up");
		chk_bit(link_clock_enable, 1'b1, "clk on");
		rdc(OFS_STATUS, 32'h0, "data state ok");
		@(posedge clk) link_in_data_state <= 1'b0;
		@(posedge clk) link_in_data_state <= 1'b1;
		rdc(OFS_STATUS, 32'h4, "link idle");
		wr(OFS_STATUS, 32'h4);
		wr(OFS_CTRL, 32'h0);
		cyc(2);
		chk_bit(link_block_reset, 1'b1, "link held");
		$display("test link done");
	endtask

	task automatic t_pin();
		cal_status_in <= 1'b1;
		cyc(3);
		chk_bit(status_output_pin, 1'b1, "pin cal");
		cal_status_in <= 1'b0;
		wr(OFS_CTRL, 32'h2);
		pll_drop();
		chk_bit(status_output_pin, 1'b1, "pin alarm");
		wr(OFS_STATUS, 32'h2);
		cyc(4);
		chk_bit(status_output_pin, 1'b0, "pin clear");
		wr(OFS_CTRL, 32'h0);
		$display("test pin done");
	endtask

	task automatic t_osc();
		for (int s = 0; s < 2; s++) begin
			wr(OFS_CTRL, 32'h1 | (32'(s) << 3));
			osc_glitch();
			rdc(OFS_STATUS, 32'h0, "osc before sync");
			sync_pulse(s == 0);
			osc_glitch();
			rdc(OFS_STATUS, 32'h0, "osc wrong source");
			sync_pulse(s == 1);
			wr(OFS_STATUS, 32'h10);
			rdc(OFS_STATUS, 32'h0, "osc equal");
			osc_glitch();
			rdc(OFS_STATUS, 32'h10, "osc upset");
			wr(OFS_STATUS, 32'h10);
			wr(OFS_CTRL, 32'h0);
		end
		$display("test osc done");
	endtask

	task automatic t_clk();
		@(posedge clk) clks_b <= 4'h5;
		@(posedge clk) clks_b <= clks_a;
		rdc(OFS_STATUS, 32'h0, "clk off half");
		@(posedge clk) begin
			clks_b <= 4'h5;
			half_clk_en <= 1'b1;
		end
		@(posedge clk) begin
			clks_b <= clks_a;
			half_clk_en <= 1'b0;
		end
		rdc(OFS_STATUS, 32'h20, "clk upset");
		wr(OFS_STATUS, 32'h20);
		$display("test clk done");
	endtask

	task automatic t_fifo();
		int n;
		wr(OFS_CTRL, 32'h5);
		@(posedge clk) lane_buffer_err <= 8'h08;
		@(posedge clk) lane_buffer_err <= 8'h00;
		n = 0;
		@(negedge clk);
		while (serializer_reset !== 1'b1 && n < 5) begin
			@(negedge clk);
			n++;
		end
		chk_bit(lane_buffer_reset, 1'b1, "buf reset");
		chk_bit(link_block_reset, 1'b1, "link reinit");
		n = 0;
		while (serializer_reset === 1'b1 && n < 30) begin
			@(negedge clk);
			n++;
		end
		chk_word(32'(n), 32'(REINIT_CYCLES), "reinit len");
		rdc(OFS_STATUS, 32'h1, "fifo bit");
		rdc(OFS_LANES, 32'h8, "lane flag");
		wr(OFS_LANES, 32'h8);
		rdc(OFS_LANES, 32'h0, "lane clear");
		wr(OFS_STATUS, 32'h1);
		wr(OFS_CTRL, 32'h0);
		$display("test fifo done");
	endtask

	task automatic t_irq_bus();
		logic [31:0] q;
		logic        e;
		pll_drop();
		chk_bit(irq, 1'b0, "irq masked");
		rdc(OFS_IRQ_STAT, 32'h3f, "irq stat");
		rdc(OFS_IRQ_STAT, 32'h0, "irq read clear");
		wr(OFS_IRQ_MASK, 32'h2);
		pll_drop();
		chk_bit(irq, 1'b1, "irq on");
		rdc(OFS_IRQ_STAT, 32'h2, "irq stat2");
		cyc(3);
		chk_bit(irq, 1'b0, "irq off");
		wr(OFS_STATUS, 32'h2);
		apb(1'b0, 8'h40, 32'h0, 1'b0, q, e);
		chk_word(q, 32'h0, "unmapped data");
		chk_bit(e, 1'b1, "unmapped err");
		$display("test irq_bus done");
	endtask

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{realign_pulse, ref_pulse_sync, lane_align_start, half_clk_en, cal_status_in} = '0;
		pll_locked = 1'b1;
		link_in_data_state = 1'b1;
		osc_acc_a = 32'h1234_5678;
		osc_acc_b = 32'h1234_5678;
		clks_a = 4'ha;
		clks_b = 4'ha;
		lane_buffer_err = 8'h00;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_ce();
		t_pll();
		t_mask();
		t_link();
		t_pin();
		t_osc();
		t_clk();
		t_fifo();
		t_irq_bus();
		report_and_stop();
	end

	// the whole run is a few hundred cycles, so this only trips on a hang
	initial begin
		#200us;
		num_errors++;
		$display("[FAIL] t=%0t watchdog", $time);
		report_and_stop();
	end
endmodule
`default_nettype wire
